// ==== src/alc_pkg.sv ====
/*
  Shared constants and types of the automatic level control block.
  Assumes the samples given to the block are the level-control output,
  16-bit two's complement, one pair per sample period.
*/
// Notes on behaviour
// RULE1 - Limiting and recovery run only while the enable bit is 1.
// RULE2 - Either channel over the detection level lowers both gains equally.
// RULE3 - With zero-cross detect on, gains change at own zero cross or timeout.
// RULE4 - Timeout select gives 128, 256, 512 or 1024 sample periods.
// RULE5 - With zero-cross detect off, one step is applied every sample.
// RULE6 - Attenuate until at or below threshold; restart when exceeded again.
// RULE7 - Threshold select: -2.5, -4.1, -6.0 or -8.5 dBFS; reset code 00.
// RULE8 - Reset band runs from detection level down to next lower level.
// RULE9 - Attenuation select gives 1, 2, 4 or 8 steps of 0.375 dB.
// RULE10 - Recovery step only after a full wait spent below the band.
// RULE11 - Wait select gives 128 sample periods doubling up to 16384.
// RULE12 - Recovery raises both gains by 1 to 4 steps, never past reference.
// RULE13 - Gain code: 0.375 dB steps, F1H +36 dB, 00H mute, reset E1H.
// RULE14 - Recovery steps are spaced by the wait period.
// RULE15 - With no zero cross, steps follow the longer timeout period.
// RULE16 - Output in the band restarts the wait; below it the wait runs.
// RULE17 - After impulse noise recovery runs 4, 8 or 16 times faster.
// RULE18 - Host changes settings only while level control is disabled.
// RULE19 - Host should program wait at least as long as the timeout.
// RULE20 - When disabled the gains follow host gain values at zero cross.
// RULE21 - Host gain writes are ignored while level control is active.
// RULE22 - On start the left gain value becomes the common gain.
// RULE23 - Impulse means an over-level run of at most four samples.
// RULE24 - Counters advance once per sample and clear when disabled; the timeout counter is not cleared when disabled.
package alc_pkg;

  localparam int SAMPLE_W = 16;
  localparam int GAIN_W   = 8;
  localparam int TIMER_W  = 15;
  localparam int RUN_W    = 3;
  localparam int ADDR_W   = 5;
  localparam int CTRL_W   = 3;
  localparam int CFG_W    = 13;

  typedef logic [GAIN_W-1:0]          gain_type;
  typedef logic signed [SAMPLE_W-1:0] sample_type;
  typedef logic [SAMPLE_W-1:0]        level_type;
  typedef logic [TIMER_W-1:0]         ticks_type;

  typedef enum logic [1:0] {
    ST_MANUAL  = 2'b00,
    ST_LIMIT   = 2'b01,
    ST_RECOVER = 2'b10
  } alc_state_type;

  // Full-scale magnitudes of the detection levels.
  localparam level_type LEVEL_M2P5 = 16'h5ffd;
  localparam level_type LEVEL_M4P1 = 16'h4fd6;
  localparam level_type LEVEL_M6P0 = 16'h4027;
  localparam level_type LEVEL_M8P5 = 16'h301c;
  localparam level_type LEVEL_M12  = 16'h2027;

  // Byte offsets on the register bus.
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG    = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_REF    = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_LEFT   = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_RIGHT  = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;

  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_ZCD_BIT    = 1;
  localparam int CTRL_POWER_BIT  = 2;
  localparam int CFG_THR_LSB     = 0;
  localparam int CFG_ATT_LSB     = 2;
  localparam int CFG_ZTO_LSB     = 4;
  localparam int CFG_WAIT_LSB    = 6;
  localparam int CFG_RSTEP_LSB   = 9;
  localparam int CFG_FAST_LSB    = 11;
  localparam int STAT_STATE_LSB  = 16;
  localparam int STAT_FAST_BIT   = 18;

  localparam gain_type GAIN_RESET = 8'he1;
  localparam gain_type GAIN_MUTE  = 8'h00;
  localparam gain_type GAIN_ONE   = 8'h01;

  // Periods counted in sample periods (1/fs).
  localparam ticks_type      ZTO_BASE_TICKS    = 15'h0080;
  localparam ticks_type      WAIT_BASE_TICKS   = 15'h0080;
  localparam logic [RUN_W-1:0] IMPULSE_MAX_TICKS = 3'h4;
  localparam logic [2:0]     FAST_SHIFT_X4     = 3'h2;
  localparam logic [2:0]     FAST_SHIFT_X8     = 3'h3;
  localparam logic [2:0]     FAST_SHIFT_X16    = 3'h4;

endpackage : alc_pkg

// ==== src/monitor_if.sv ====
/*
  Per-channel level and zero-cross flags, from a channel monitor to the
  level control core. All flags are one-cycle pulses on a sample strobe.
*/
`timescale 1ns/10ps
`default_nettype none
interface monitor_if;
  logic zero_cross;
  logic over_limit;
  logic in_band;
  modport source (output zero_cross, output over_limit, output in_band);
  modport sink   (input zero_cross, input over_limit, input in_band);
endinterface : monitor_if
`default_nettype wire

// ==== src/channel_monitor.sv ====
/*
  Level classifier and zero-cross detector for one channel.
  Assumes one sample per strobe, synchronous to sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module channel_monitor (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              tick,
  input  wire alc_pkg::sample_type sample,
  input  wire logic [1:0]        thresh_sel,
  monitor_if.source              mon
);
  import alc_pkg::*;

  logic      prev_sign;
  level_type mag;
  level_type lim;
  level_type floor_level;

  // Sign of the previous sample; a sign change marks a zero crossing.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_sign <= 1'b0;
    end else if (tick) begin
      prev_sign <= sample[SAMPLE_W-1];
    end
  end

  // Detection level and the floor of the band below it.
  always_comb begin
    mag = sample[SAMPLE_W-1] ? level_type'(-sample) : level_type'(sample);
    unique case (thresh_sel) // [RULE7] [RULE8]
      2'b00: begin lim = LEVEL_M2P5; floor_level = LEVEL_M4P1; end
      2'b01: begin lim = LEVEL_M4P1; floor_level = LEVEL_M6P0; end
      2'b10: begin lim = LEVEL_M6P0; floor_level = LEVEL_M8P5; end
      2'b11: begin lim = LEVEL_M8P5; floor_level = LEVEL_M12;  end
    endcase
  end

  // An exact zero also counts as a crossing.
  assign mon.zero_cross = tick &&
         ((sample[SAMPLE_W-1] != prev_sign) || (mag == '0));
  assign mon.over_limit = tick && (mag >= lim);
  assign mon.in_band    = tick && (mag < lim) && (mag >= floor_level);
endmodule : channel_monitor
`default_nettype wire

// ==== src/fs_timer.sv ====
/*
  Sample-period counter with restart; pulses when the limit is reached
  and then starts over. Assumes limit is at least one.
*/
`timescale 1ns/10ps
`default_nettype none
module fs_timer (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              tick,
  input  wire logic              restart,
  input  wire alc_pkg::ticks_type limit,
  output var  alc_pkg::ticks_type count,
  output logic                   expired
);
  import alc_pkg::*;

  logic at_end;
  assign at_end  = (count == limit - 1'b1);
  assign expired = tick && !restart && at_end;

  // Restart wins over counting so a restart never loses a period. [RULE24]
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (restart || expired) begin
      count <= '0;
    end else if (tick) begin
      count <= count + 1'b1;
    end
  end
endmodule : fs_timer
`default_nettype wire

// ==== src/alc_core.sv ====
/*
  Stereo automatic level control: limiter, recovery, fast recovery and
  manual gain, with an Avalon-MM register slave.
  Assumes sample_valid pulses once per sample period and that the samples
  are the level-control output that the gains act on.
*/
`timescale 1ns/10ps
`default_nettype none
module alc_core (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_b,
  input  wire logic [alc_pkg::ADDR_W-1:0] address,
  input  wire logic                  read,
  input  wire logic                  write,
  input  wire logic [3:0]            byteenable,
  input  wire logic [31:0]           writedata,
  output logic      [31:0]           readdata,
  output logic                       waitrequest,
  input  wire logic                  sample_valid,
  input  wire alc_pkg::sample_type   left_sample,
  input  wire alc_pkg::sample_type   right_sample,
  output alc_pkg::gain_type          applied_left_gain,
  output alc_pkg::gain_type          applied_right_gain
);
  import alc_pkg::*;

  // ------------------------------------------------------------------
  // Register slave
  // ------------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl;
  logic [CFG_W-1:0]  cfg;
  gain_type          recovery_reference_level;
  gain_type          left_level_gain;
  gain_type          right_level_gain;
  logic              ack;
  logic              wr_fire;
  logic [31:0]       wmask;
  logic [31:0]       next_readdata;

  logic alc_enable;
  logic zero_cross_disable;
  logic dac_power_enable;
  logic active;
  logic active_q;
  logic started;
  logic fast;
  alc_state_type state;
  alc_state_type next_state;

  assign alc_enable         = ctrl[CTRL_ENABLE_BIT];
  assign zero_cross_disable = ctrl[CTRL_ZCD_BIT];
  assign dac_power_enable   = ctrl[CTRL_POWER_BIT];
  assign active             = alc_enable && dac_power_enable; // [RULE1]
  assign started            = active && !active_q;

  // Every access waits exactly one cycle, which gives read data a flop.
  assign waitrequest = (read || write) && !ack;
  assign wr_fire     = write && ack;
  assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                  {8{byteenable[1]}}, {8{byteenable[0]}}};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack <= 1'b0;
    end else begin
      ack <= (read || write) && !ack;
    end
  end

  // Control and settings take writes at any time.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl                     <= '0;
      cfg                      <= '0;
      recovery_reference_level <= GAIN_RESET; // [RULE13]
    end else if (wr_fire) begin
      unique case (address)
        OFS_CTRL: ctrl <= (ctrl & ~wmask[CTRL_W-1:0]) |
                          (writedata[CTRL_W-1:0] & wmask[CTRL_W-1:0]);
        OFS_CFG:  cfg  <= (cfg & ~wmask[CFG_W-1:0]) |
                          (writedata[CFG_W-1:0] & wmask[CFG_W-1:0]);
        OFS_REF:  if (byteenable[0]) begin
          recovery_reference_level <= writedata[GAIN_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // Host gains are frozen while level control runs.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      left_level_gain  <= GAIN_RESET;
      right_level_gain <= GAIN_RESET;
    end else if (wr_fire && !active && byteenable[0]) begin // [RULE21]
      if (address == OFS_LEFT) begin
        left_level_gain <= writedata[GAIN_W-1:0];
      end
      if (address == OFS_RIGHT) begin
        right_level_gain <= writedata[GAIN_W-1:0];
      end
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    next_readdata = '0;
    unique case (address)
      OFS_CTRL:   next_readdata[CTRL_W-1:0] = ctrl;
      OFS_CFG:    next_readdata[CFG_W-1:0]  = cfg;
      OFS_REF:    next_readdata[GAIN_W-1:0] = recovery_reference_level;
      OFS_LEFT:   next_readdata[GAIN_W-1:0] = left_level_gain;
      OFS_RIGHT:  next_readdata[GAIN_W-1:0] = right_level_gain;
      OFS_STATUS: begin
        next_readdata[2*GAIN_W-1:0] = {applied_right_gain,
                                       applied_left_gain};
        next_readdata[STAT_STATE_LSB+1:STAT_STATE_LSB] = state;
        next_readdata[STAT_FAST_BIT] = fast;
      end
      default: next_readdata = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= '0;
    end else if (read && !ack) begin
      readdata <= next_readdata;
    end
  end

  // ------------------------------------------------------------------
  // Level detection and timers
  // ------------------------------------------------------------------
  monitor_if mon_l ();
  monitor_if mon_r ();

  logic [1:0] thresh_sel;
  logic [1:0] att_sel;
  logic [1:0] zto_sel;
  logic [2:0] wait_sel;
  logic [1:0] rstep_sel;
  logic [1:0] fast_sel;
  assign thresh_sel = cfg[CFG_THR_LSB+1:CFG_THR_LSB];
  assign att_sel    = cfg[CFG_ATT_LSB+1:CFG_ATT_LSB];
  assign zto_sel    = cfg[CFG_ZTO_LSB+1:CFG_ZTO_LSB];
  assign wait_sel   = cfg[CFG_WAIT_LSB+2:CFG_WAIT_LSB];
  assign rstep_sel  = cfg[CFG_RSTEP_LSB+1:CFG_RSTEP_LSB];
  assign fast_sel   = cfg[CFG_FAST_LSB+1:CFG_FAST_LSB];

  channel_monitor u_mon_l (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .tick       (sample_valid),
    .sample     (left_sample),
    .thresh_sel (thresh_sel),
    .mon        (mon_l.source)
  );

  channel_monitor u_mon_r (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .tick       (sample_valid),
    .sample     (right_sample),
    .thresh_sel (thresh_sel),
    .mon        (mon_r.source)
  );

  logic      tick;
  logic      over_any;
  logic      band_any;
  gain_type  target_l;
  gain_type  target_r;
  gain_type  next_target_l;
  gain_type  next_target_r;
  logic      pending;
  logic      limit_act;
  logic      recov_act;
  logic      immediate;
  logic      apply_l;
  logic      apply_r;
  ticks_type zto_limit;
  ticks_type wait_base;
  ticks_type wait_limit;
  ticks_type wait_count;
  logic      zto_exp;
  logic      wait_exp;
  logic      wait_restart;
  logic [2:0] fast_shift;

  assign tick     = sample_valid;
  assign over_any = mon_l.over_limit || mon_r.over_limit; // [RULE2]
  assign band_any = mon_l.in_band || mon_r.in_band;
  assign pending  = (applied_left_gain != target_l) ||
                    (applied_right_gain != target_r);

  // Fast recovery divides the wait; the spare code keeps the 4x speed.
  always_comb begin
    unique case (fast_sel) // [RULE17]
      2'b01:   fast_shift = FAST_SHIFT_X8;
      2'b10:   fast_shift = FAST_SHIFT_X16;
      default: fast_shift = FAST_SHIFT_X4;
    endcase
  end

  assign zto_limit  = ZTO_BASE_TICKS << zto_sel;   // [RULE4]
  assign wait_base  = WAIT_BASE_TICKS << wait_sel; // [RULE11]
  assign wait_limit = fast ? (wait_base >> fast_shift) : wait_base;

  // Any level at or above the band floor restarts the wait. A step
  // restarts it through the expiry itself, which keeps the step decision
  // out of its own restart path.
  assign wait_restart = !active || started ||
                        (tick && (over_any || band_any)); // [RULE16]

  fs_timer u_wait (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .tick    (tick),
    .restart (wait_restart), // [RULE10] [RULE24]
    .limit   (wait_limit),
    .count   (wait_count),
    .expired (wait_exp)
  );

  // A new target restarts the timeout, so equal rewrites do not.
  fs_timer u_zto (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .tick    (tick),
    .restart ((next_target_l != target_l) ||
              (next_target_r != target_r)),
    .limit   (zto_limit),
    .count   (),
    .expired (zto_exp)
  );

  // ------------------------------------------------------------------
  // Gain control
  // ------------------------------------------------------------------
  gain_type          step_lim;
  gain_type          step_rec;
  logic [GAIN_W:0]   rec_sum;

  assign step_lim = zero_cross_disable ? GAIN_ONE :
                    gain_type'(GAIN_ONE << att_sel); // [RULE5] [RULE9]
  assign step_rec = gain_type'(rstep_sel) + GAIN_ONE; // [RULE12]
  assign rec_sum  = {1'b0, target_l} + {1'b0, step_rec};

  // With zero-cross detect on, the next action waits for the last one
  // to land on both channels, which paces the limiter.
  assign limit_act = tick && active && active_q && over_any &&
                     (zero_cross_disable || !pending) &&
                     (target_l != GAIN_MUTE); // [RULE6]
  assign recov_act = tick && active && active_q && !over_any &&
                     wait_exp && !pending &&
                     (target_l < recovery_reference_level); // [RULE14]

  always_comb begin
    next_target_l = target_l;
    next_target_r = target_r;
    if (!active) begin
      next_target_l = left_level_gain; // [RULE20]
      next_target_r = right_level_gain;
    end else if (started) begin
      next_target_l = left_level_gain; // [RULE22]
      next_target_r = left_level_gain;
    end else if (limit_act) begin
      next_target_l = (target_l >= step_lim) ? target_l - step_lim
                                             : GAIN_MUTE; // [RULE2]
      next_target_r = next_target_l;
    end else if (recov_act) begin
      next_target_l = (rec_sum > {1'b0, recovery_reference_level}) ?
                      recovery_reference_level :
                      rec_sum[GAIN_W-1:0]; // [RULE12]
      next_target_r = next_target_l;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      target_l <= GAIN_RESET;
      target_r <= GAIN_RESET;
      active_q <= 1'b0;
    end else begin
      target_l <= next_target_l;
      target_r <= next_target_r;
      active_q <= active;
    end
  end

  // Each channel takes the target at its own zero crossing, on the timeout,
  // or every sample in immediate mode; a long timeout thus also paces recovery. [RULE15]
  assign immediate = active && zero_cross_disable;
  assign apply_l = tick && (immediate || mon_l.zero_cross || zto_exp);
  assign apply_r = tick && (immediate || mon_r.zero_cross || zto_exp);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      applied_left_gain  <= GAIN_RESET;
      applied_right_gain <= GAIN_RESET;
    end else begin
      if (apply_l) begin
        applied_left_gain <= target_l; // [RULE3] [RULE5]
      end
      if (apply_r) begin
        applied_right_gain <= target_r; // [RULE3]
      end
    end
  end

  // ------------------------------------------------------------------
  // Mode and impulse detection
  // ------------------------------------------------------------------
  logic [RUN_W-1:0] over_run;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_MANUAL: if (active) next_state = ST_RECOVER;
      ST_LIMIT, ST_RECOVER: begin
        if (!active) next_state = ST_MANUAL;
        else if (tick) next_state = over_any ? ST_LIMIT : ST_RECOVER;
      end
      default: next_state = ST_MANUAL;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_MANUAL;
    end else begin
      state <= next_state;
    end
  end

  // Length of the current over-level run, saturating.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      over_run <= '0;
    end else if (!active || (tick && !over_any)) begin
      over_run <= '0;
    end else if (tick && (over_run != '1)) begin
      over_run <= over_run + 1'b1;
    end
  end

  // A short burst counts as an impulse; fast mode lasts until the
  // gain is back at the reference or a longer burst ends.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fast <= 1'b0;
    end else if (!active) begin
      fast <= 1'b0;
    end else if (tick && !over_any && state == ST_LIMIT) begin
      fast <= (over_run <= IMPULSE_MAX_TICKS); // [RULE23]
    end else if (recov_act &&
                 next_target_l == recovery_reference_level) begin
      fast <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_gated;
    !active |-> !limit_act && !recov_act;
  endproperty
  a_gated: assert property (p_gated) // [RULE1]
    else $error("gain action while disabled");

  property p_equal;
    active && active_q |-> target_l == target_r;
  endproperty
  a_equal: assert property (p_equal) // [RULE2]
    else $error("channel gains differ while active");

  property p_apply;
    $changed(applied_left_gain) |-> $past(apply_l);
  endproperty
  a_apply: assert property (p_apply) // [RULE3]
    else $error("left gain changed without crossing or timeout");

  property p_immediate;
    immediate && tick |=> applied_left_gain == $past(target_l) &&
                          applied_right_gain == $past(target_r);
  endproperty
  a_immediate: assert property (p_immediate) // [RULE5]
    else $error("gain not applied at once");

  property p_step;
    limit_act && target_l >= step_lim |=>
      target_l == $past(target_l) - $past(step_lim);
  endproperty
  a_step: assert property (p_step) // [RULE9]
    else $error("wrong attenuation step");

  property p_wait;
    recov_act |-> wait_exp && wait_count == wait_limit - 1'b1;
  endproperty
  a_wait: assert property (p_wait) // [RULE10]
    else $error("recovery before wait ended");

  property p_ceiling;
    recov_act |=> target_l <= recovery_reference_level &&
                  target_l > $past(target_l);
  endproperty
  a_ceiling: assert property (p_ceiling) // [RULE12]
    else $error("recovery past reference");

  property p_band;
    tick && active && band_any |=> wait_count == '0;
  endproperty
  a_band: assert property (p_band) // [RULE16]
    else $error("band level did not restart wait");

  property p_hold;
    active && wr_fire && address == OFS_LEFT |=> $stable(left_level_gain);
  endproperty
  a_hold: assert property (p_hold) // [RULE21]
    else $error("gain write taken while active");

  property p_start;
    started |=> target_l == $past(left_level_gain) &&
                target_r == $past(left_level_gain);
  endproperty
  a_start: assert property (p_start) // [RULE22]
    else $error("start gain not taken from left");

  property p_clear;
    !active |=> wait_count == '0;
  endproperty
  a_clear: assert property (p_clear) // [RULE24]
    else $error("wait counter not cleared");

  c_limit: cover property (limit_act ##1 state == ST_LIMIT);
  c_recover: cover property (recov_act);
  c_fast: cover property ($rose(fast));
endmodule : alc_core
`default_nettype wire

// ==== verif/audio_source.sv ====
/* Upstream sample source: one stereo pair every fourth clock, sign
   alternating. Assumes it shares sys_clk with the level control. */
`timescale 1ns/10ps
`default_nettype none
module audio_source (
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  input  wire alc_pkg::sample_type amp,
  output logic                     sample_valid,
  output alc_pkg::sample_type      left_sample,
  output alc_pkg::sample_type      right_sample
);
  import alc_pkg::*;
  logic [1:0] phase;
  logic       neg;
  // Strobe counter; the sign flips on every strobe so each tick crosses.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 2'h0;
      neg   <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) neg <= ~neg;
    end
  end
  // Off the strobe the lines carry the inverse, so stale data never helps.
  assign sample_valid = (phase == 2'h3);
  assign left_sample  = sample_valid ? (neg ? -amp : amp) : ~amp;
  assign right_sample = left_sample;
endmodule : audio_source
`default_nettype wire

// ==== verif/automatic_level_control_tb_top.sv ====
/* Register-driven bench of the level control core.
   Assumes the slave answers through waitrequest, one pair per 4 clocks. */
`timescale 1ns/10ps
`default_nettype none
module automatic_level_control_tb_top;
  import alc_pkg::*;
  logic              sys_clk   = 1'b0;
  logic              rst_b     = 1'b0;
  logic [ADDR_W-1:0] address   = '0;
  logic              read      = 1'b0;
  logic              write     = 1'b0;
  logic [31:0]       writedata = '0;
  logic [31:0]       readdata, q;
  logic              waitrequest, sample_valid;
  sample_type        amp = '0;
  sample_type        left_sample, right_sample;
  gain_type          gl, gr, g0;
  int                fail_count = 0;
  int                checks = 0;
  always #5 sys_clk = ~sys_clk;
  alc_core DUT (.sys_clk(sys_clk), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .byteenable(4'hf), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .sample_valid(sample_valid), .left_sample(left_sample),
    .right_sample(right_sample), .applied_left_gain(gl),
    .applied_right_gain(gr));
  audio_source src (.sys_clk(sys_clk), .rst_b(rst_b), .amp(amp),
    .sample_valid(sample_valid), .left_sample(left_sample),
    .right_sample(right_sample));
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Request held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail_count++;
      stop_test();
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic ticks(input int n);
    repeat (4 * n) @(posedge sys_clk);
  endtask : ticks
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // Watchdog well beyond the roughly 4300 cycles the tests take.
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    bus(0, OFS_CTRL, 0);
    check("ctrl", q, 32'h0);
    bus(0, OFS_REF, 0);
    check("ref", q, 32'he1);
    bus(0, OFS_STATUS, 0);
    check("status", q, 32'he1e1);
    bus(0, 5'h18, 0);
    check("unmapped", q, 32'h0);
    $display("test reset done");
    // Manual mode: a loud signal must not move the gains.
    amp <= 16'h7000;
    bus(1, OFS_CTRL, 32'h4);
    bus(1, OFS_RIGHT, 32'hc6);
    ticks(130);
    bus(0, OFS_STATUS, 0);
    check("manual gains", q, 32'hc6e1);
    $display("test manual done");
    // Start with unequal gains, quiet input, reference equal to start.
    amp <= 16'h0100;
    bus(1, OFS_CTRL, 32'h5);
    ticks(300);
    bus(0, OFS_STATUS, 0);
    check("start gains", q[15:0], 32'he1e1);
    $display("test start done");
    // Immediate mode with the largest step code still moves one step.
    bus(1, OFS_CTRL, 32'h4);
    bus(1, OFS_CFG, 32'hc);
    ticks(130);
    bus(1, OFS_CTRL, 32'h7);
    amp <= 16'h7000;
    ticks(40);
    bus(0, OFS_STATUS, 0);
    check("limit state", q[17:16], 32'h1);
    check("equal gains", q[7:0] == q[15:8], 32'h1);
    check("one step", q[7:0] > 8'h90 && q[7:0] < 8'he1, 32'h1);
    bus(1, OFS_LEFT, 32'h40);
    bus(0, OFS_LEFT, 0);
    check("left kept", q, 32'he1);
    $display("test limit done");
    // Quiet input: one recovery step per full wait of 128 samples.
    amp <= 16'h0100;
    ticks(4);
    bus(0, OFS_STATUS, 0);
    g0 = q[7:0];
    ticks(100);
    bus(0, OFS_STATUS, 0);
    check("no early step", q[7:0], g0);
    ticks(200);
    bus(0, OFS_STATUS, 0);
    check("recovered", q[15:0], {g0 + 8'h2, g0 + 8'h2});
    check("recover state", q[17:16], 32'h2);
    $display("test recover done");
    // Disable: gains return to the last accepted host values.
    amp <= 16'h0100;
    bus(1, OFS_CTRL, 32'h4);
    ticks(150);
    bus(0, OFS_STATUS, 0);
    check("restore", q, 32'hc6e1);
    check("restore pins", {gr, gl}, 32'hc6e1);
    $display("test restore done");
    stop_test();
  end
endmodule : automatic_level_control_tb_top
`default_nettype wire
